// file: shared/trh_cfg.svh
/*
 * header length, codes and reset values for the tunnel header
 * framer. assumes nothing beyond a tool that honours include guards.
 */
`ifndef TRH_CFG_SVH
`define TRH_CFG_SVH

`define TRH_HDR_BYTES     12
`define TRH_RTP_VERSION   2'h2
`define TRH_CSRC_COUNT    4'h0
`define TRH_PROTO_VERSION 2'h1
`define TRH_PT_SOURCE     7'h51
`define TRH_PT_LINK       7'h52
`define TRH_PT_XMIT_LINK  7'h61
`define TRH_SEQ_RESET     16'h0000
`define TRH_FIFO_DEPTH    16
`define TRH_FIFO_AW       4

`endif

// file: shared/trh_pkg.sv
/*
 * types shared by both ends of the tunnel header link.
 * assumes trh_cfg.svh is on the include path.
 */
package trh_pkg;
  `include "trh_cfg.svh"

  typedef enum logic [6:0] {
    TRH_PT_SRC  = `TRH_PT_SOURCE,
    TRH_PT_LNK  = `TRH_PT_LINK,
    TRH_PT_XMIT = `TRH_PT_XMIT_LINK
  } trh_pt_t;

  // one header, 96 bits, field order as on the wire (msb first)
  typedef struct packed {
    logic [1:0]  version;
    logic        padding;
    logic        extension;
    logic [3:0]  csrc_count;
    logic        start_present;
    logic [6:0]  payload_type;
    logic [15:0] seq_num;
    logic [31:0] time_word;
    logic [1:0]  proto_version;
    logic [13:0] type_bits;
    logic [15:0] start_offset;
  } trh_hdr_t;

  typedef enum logic [1:0] {
    TRH_IDLE = 2'b00,
    TRH_SEND = 2'b01,
    TRH_DONE = 2'b11
  } trh_state_t;
endpackage

// file: shared/trh_link_if.sv
/*
 * byte stream carrying packed tunnel headers from the encapsulator end to
 * the decapsulator end. assumes both ends share clk_sys.
 */
`timescale 1ns/1ps
interface trh_link_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       last;

  modport enc (output valid, output data, output last, input ready);
  modport dec (input valid, input data, input last, output ready);
endinterface

// file: hw/trh_fifo.sv
/*
 * generic valid/ready fifo, width and depth as parameters.
 * assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module trh_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push  = in_valid && in_ready;
  wire              pop   = out_valid && out_ready;
  wire              full  = (wr_q[AW] != rd_q[AW]) &&
                            (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire              empty = (wr_q == rd_q);

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// file: hw/trh_encap.sv
/*
 * encapsulator end: builds one 12-byte tunnel header per request and
 * streams it msb-first through a 16-entry fifo onto the link.
 * assumes the user holds its request fields stable while req is high,
 * and that the far end drains the link about one byte a clock.
 */
// How it works
// - version field always binary 10
// - contributor count field always zero
// - padding bit passed through from user
// - extension bit constant per stream
// - start flag set when inner start present
// - payload type selects tunnel variant
// - sequence counter increments by one, wraps
// - sequence counter may start from seed
// - types 81/82 carry earliest time, else zero
// - time word is seconds then fraction
// - type 97 time is delivery deadline
// - header version field driven to 01
// - type 97 carries redundancy count
// - type 97 carries channel count less one
// - offset counts bytes after header
// - consumer follows inner length fields
// - only data packets, no control stream
// - no start means flag and offset zero
`timescale 1ns/1ps
module trh_encap
  import trh_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        req,
  output logic             busy,
  input  wire logic        padding,
  input  wire logic        extension,
  input  wire logic        start_present,
  input  wire logic [15:0] start_offset,
  input  wire logic [6:0]  payload_type,
  input  wire logic        has_info,
  input  wire logic [15:0] time_seconds,
  input  wire logic [15:0] time_fraction,
  input  wire logic [31:0] deadline,
  input  wire logic [1:0]  redundancy,
  input  wire logic [1:0]  channel_count_less_one,
  input  wire logic        seed_load,
  input  wire logic [15:0] seed_value,
  output logic [15:0]      seq_now,
  trh_link_if.enc          link
);
  trh_state_t  state_q;
  trh_state_t  state_d;
  logic [95:0] sh_q;
  logic [3:0]  cnt_q;
  logic [15:0] seq_q;
  logic        ext_q;
  logic        ext_locked_q;
  trh_hdr_t    hdr;
  logic        f_ready;
  logic [31:0] time_sel;
  logic [13:0] type_sel;
  logic [15:0] offset_sel;
  logic [8:0]  lane;

  // =====================================================================
  // request and type decode
  // unknown types fall through both tests and get zero time and type fields
  wire is_src_lnk = (payload_type == `TRH_PT_SOURCE) ||
                    (payload_type == `TRH_PT_LINK);
  wire is_xmit    = (payload_type == `TRH_PT_XMIT_LINK);
  wire sending    = (state_q == TRH_SEND);
  wire push       = sending && f_ready;
  wire take       = (state_q == TRH_IDLE) && req;
  wire last_byte  = (cnt_q == 4'(`TRH_HDR_BYTES - 1));
  wire finished   = push && last_byte;
  // a seed is refused mid-header so one header never mixes two counts
  wire seed_take  = seed_load && !busy;
  wire seq_step   = (state_q == TRH_DONE);
  wire ext_now    = ext_locked_q ? ext_q : extension;

  // =====================================================================
  // field selection
  // a time word with no source behind it reads zero, never stale data
  assign time_sel   = (is_src_lnk && has_info) ?
                      {time_seconds, time_fraction} :
                      (is_xmit ? deadline : 32'h0);
  assign type_sel   = is_xmit ?
                      {redundancy, channel_count_less_one, 10'h000} :
                      14'h0;
  assign offset_sel = start_present ? start_offset
                                    : 16'h0000;
  assign lane       = {last_byte, sh_q[95:88]};

  // =====================================================================
  // header assembly
  // reserved bits start at zero; known fields are laid over them
  always_comb begin
    hdr               = '0;
    hdr.version       = `TRH_RTP_VERSION;
    hdr.padding       = padding;
    hdr.extension     = ext_now;
    hdr.csrc_count    = `TRH_CSRC_COUNT;
    hdr.start_present = start_present;
    hdr.payload_type  = payload_type;
    hdr.seq_num       = seq_q;
    hdr.time_word     = time_sel;
    hdr.proto_version = `TRH_PROTO_VERSION;
    hdr.type_bits     = type_sel;
    hdr.start_offset  = offset_sel;
  end

  // =====================================================================
  // sequencing
  // the spare DONE cycle lets the counter step before the next take
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TRH_IDLE: begin
        if (req) begin
          state_d = TRH_SEND;
        end
      end
      TRH_SEND: begin
        if (finished) begin
          state_d = TRH_DONE;
        end
      end
      TRH_DONE: begin
        state_d = TRH_IDLE;
      end
      default: begin
        state_d = TRH_IDLE;
      end
    endcase
  end

  assign busy    = (state_q != TRH_IDLE);
  assign seq_now = seq_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= TRH_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================================
  // header shifter; the header is frozen at take, so the user fields
  // need only be valid on that one edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sh_q  <= '0;
      cnt_q <= 4'h0;
    end else if (take) begin
      sh_q  <= hdr;
      cnt_q <= 4'h0;
    end else if (push) begin
      sh_q  <= {sh_q[87:0], 8'h00};
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // =====================================================================
  // sequence counter
  // only data headers are ever emitted, never control packets, so one
  // step per header keeps the stream free of gaps
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_q <= `TRH_SEQ_RESET;
    end else if (seed_take) begin
      seq_q <= seed_value;
    end else if (seq_step) begin
      seq_q <= seq_q + 16'h0001;
    end
  end

  // =====================================================================
  // extension lock: the first header after reset fixes the bit, so every
  // header in the stream keeps the same length
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_q        <= 1'h0;
      ext_locked_q <= 1'h0;
    end else if (take) begin
      ext_q        <= ext_now;
      ext_locked_q <= 1'h1;
    end
  end

  // =====================================================================
  // output buffering; a stalled consumer backs up into busy
  // sixteen entries hold a whole header, so a ready consumer never stalls
  trh_fifo #(
    .WIDTH (9),
    .DEPTH (`TRH_FIFO_DEPTH),
    .AW    (`TRH_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (sending),
    .in_ready  (f_ready),
    .in_data   (lane),
    .out_valid (link.valid),
    .out_ready (link.ready),
    .out_data  ({link.last, link.data})
  );
endmodule

// file: hw/trh_decap.sv
/*
 * decapsulator end: collects 12 header bytes from the link and presents
 * decoded fields for one cycle. assumes the encapsulator end framing.
 */
`timescale 1ns/1ps
module trh_decap
  import trh_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  trh_link_if.dec          link,
  output logic             hdr_valid,
  output logic             padding,
  output logic             extension,
  output logic             start_present,
  output logic [15:0]      start_offset,
  output logic [6:0]       payload_type,
  output logic [15:0]      seq_num,
  output logic [31:0]      time_word,
  output logic [1:0]       redundancy,
  output logic [1:0]       channel_count_less_one,
  output logic             type_unknown,
  output logic             seq_gap
);
  logic [95:0] acc_q;
  logic        done_q;
  logic        seen_q;
  logic [15:0] prev_q;
  trh_hdr_t    h;

  assign link.ready = 1'b1;
  assign h          = acc_q;
  wire   take       = link.valid && link.ready;
  wire   xmit       = (h.payload_type == `TRH_PT_XMIT_LINK);
  wire   known      = xmit || (h.payload_type == `TRH_PT_SOURCE) ||
                      (h.payload_type == `TRH_PT_LINK);

  // =====================================================================
  // decoded fields, valid with hdr_valid
  assign hdr_valid     = done_q;
  assign padding       = h.padding;
  assign extension     = h.extension;
  assign start_present = h.start_present;
  // offset is meaningless without a start, so it is forced to zero
  assign start_offset  = h.start_present ? h.start_offset
                                         : 16'h0000;
  assign payload_type  = h.payload_type;
  assign seq_num       = h.seq_num;
  assign time_word     = known ? h.time_word : 32'h0;
  assign redundancy    = xmit ? h.type_bits[13:12] : 2'h0;
  assign channel_count_less_one =
                         xmit ? h.type_bits[11:10] : 2'h0;
  assign type_unknown  = done_q && !known;
  // inner packet walking by length fields is left to the user side
  assign seq_gap       = done_q && seen_q &&
                         (h.seq_num != prev_q + 16'h0001);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_q  <= '0;
      done_q <= 1'b0;
      seen_q <= 1'b0;
      prev_q <= 16'h0000;
    end else begin
      done_q <= take && link.last;
      if (take) begin
        acc_q <= {acc_q[87:0], link.data};
      end
      if (done_q) begin
        seen_q <= 1'b1;
        prev_q <= h.seq_num;
      end
    end
  end
endmodule

// file: sim/trh_link_checker.sv
/* wire checker for the tunnel header byte stream.
   assumes one clk_sys domain and 12 bytes per header. */
`timescale 1ns/1ps
module trh_link_checker
  import trh_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       valid,
  input wire logic       ready,
  input wire logic [7:0] data,
  input wire logic       last
);
  // ==========
  // frame tracking
  logic [3:0]  cnt_q;
  logic [6:0]  pt_q;
  logic        mk_q;
  logic        pv_q;
  logic [7:0]  sh_q;
  logic [15:0] ps_q;
  wire         tk = valid & ready;
  wire  [15:0] sq = {sh_q, data};
  wire         kn = pt_q inside {TRH_PT_SRC, TRH_PT_LNK, TRH_PT_XMIT};

  // byte index counts itself, not from last, so a bad last is caught
  always_ff @(posedge clk_sys) begin
    if (sys_rst) cnt_q <= 4'h0;
    else if (tk) cnt_q <= (cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
    pv_q <= !sys_rst & (pv_q | (tk & cnt_q == 4'h3));
    if (tk && cnt_q == 4'h1) {mk_q, pt_q} <= data;
    if (tk && cnt_q == 4'h2) sh_q <= data;
    if (tk && cnt_q == 4'h3) ps_q <= sq;
  end

  // ==========
  // assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_ver; tk && cnt_q == 4'h0 |-> data[7:6] == 2'h2; endproperty
  property p_cc; tk && cnt_q == 4'h0 |-> data[3:0] == 4'h0; endproperty
  property p_seq;
    tk && cnt_q == 4'h3 && pv_q |-> sq == ps_q + 16'h0001;
  endproperty
  property p_pv; tk && cnt_q == 4'h8 |-> data[7:6] == 2'h1; endproperty
  property p_rsv; tk && cnt_q == 4'h9 |-> data == 8'h00; endproperty
  property p_r97;
    tk && cnt_q == 4'h8 && pt_q != TRH_PT_XMIT |-> data[5:0] == 6'h00;
  endproperty
  property p_unk;
    tk && cnt_q inside {4'h4, 4'h5, 4'h6, 4'h7} && !kn |-> data == 8'h00;
  endproperty
  property p_off;
    tk && cnt_q inside {4'hA, 4'hB} && !mk_q |-> data == 8'h00;
  endproperty
  property p_last; tk |-> last == (cnt_q == 4'hB); endproperty
  a_ver: assert property (p_ver) else $error("bad version");
  a_cc: assert property (p_cc) else $error("bad csrc count");
  a_seq: assert property (p_seq) else $error("sequence step");
  a_pv: assert property (p_pv) else $error("header version");
  a_rsv: assert property (p_rsv) else $error("reserved byte");
  a_r97: assert property (p_r97) else $error("type field");
  a_unk: assert property (p_unk) else $error("unknown time");
  a_off: assert property (p_off) else $error("offset nonzero");
  a_last: assert property (p_last) else $error("framing");
  c_last: cover property (tk && last);
  c_xmit: cover property (tk && cnt_q == 4'h8 && pt_q == TRH_PT_XMIT);
  c_mark: cover property (tk && cnt_q == 4'hA && mk_q);
endmodule

// file: sim/tb_top.sv
/* end-to-end bench: encapsulator to decapsulator over the link.
   assumes the design files and trh_pkg are compiled first. */
`timescale 1ns/1ps
module tb_top;
  import trh_pkg::*;
  logic        clk_sys = 0, sys_rst = 1, req = 0, busy, hv, xl;
  logic        padding = 0, extension = 0, start_present = 0;
  logic        has_info = 0, seed_load = 0;
  logic [15:0] start_offset = 0, time_seconds = 0, time_fraction = 0;
  logic [15:0] seed_value = 0, seq_now, nx = 16'hFFFE;
  logic [31:0] deadline = 0;
  logic [6:0]  payload_type = 0;
  logic [1:0]  redundancy = 0, channel_count_less_one = 0;
  logic [79:0] e, exp_q[$];
  wire  [78:0] got;
  wire         sg;
  logic [6:0]  tbl [4] = '{TRH_PT_SRC, TRH_PT_LNK, TRH_PT_XMIT, 7'h33};
  int          fail_count = 0, n_compared = 0, cyc = 0;

  always #10 clk_sys = ~clk_sys;
  trh_link_if lk();
  trh_encap trh_encap_inst(.clk_sys, .sys_rst, .req, .busy, .padding,
    .extension, .start_present, .start_offset, .payload_type, .has_info,
    .time_seconds, .time_fraction, .deadline, .redundancy,
    .channel_count_less_one, .seed_load, .seed_value, .seq_now,
    .link(lk));
  trh_decap trh_decap_inst(.clk_sys, .sys_rst, .link(lk), .hdr_valid(hv),
    .padding(got[78]), .extension(got[77]), .start_present(got[76]),
    .start_offset(got[75:60]), .payload_type(got[59:53]),
    .seq_num(got[52:37]), .time_word(got[36:5]), .redundancy(got[4:3]),
    .channel_count_less_one(got[2:1]), .type_unknown(got[0]),
    .seq_gap(sg));
  trh_link_checker trh_link_checker_inst(.clk_sys, .sys_rst,
    .valid(lk.valid), .ready(lk.ready), .data(lk.data), .last(lk.last));

  // ==========
  // helpers
  task automatic check(input logic [78:0] g, input logic [78:0] x);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %0t header field mismatch", $time);
    end
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // random fields; expectation noted before the request goes out
  task automatic send(input int i);
    logic [31:0] r;
    logic        k;
    r = $urandom;
    @(negedge clk_sys);
    payload_type = tbl[i % 4];
    {padding, extension, start_present, has_info} = r[3:0];
    {redundancy, channel_count_less_one} = r[7:4];
    start_offset = (i % 5 == 0) ? 16'h0000 : r[31:16];
    {time_seconds, time_fraction} = $urandom;
    deadline = (i % 6 == 0) ? 32'h0 : $urandom;
    if (i % 20 == 0) xl = extension;
    k = payload_type inside {TRH_PT_SRC, TRH_PT_LNK};
    exp_q.push_back({1'h0, padding, xl, start_present,
      start_present ? start_offset : 16'h0000, payload_type, nx,
      payload_type == TRH_PT_XMIT ? deadline :
      k && has_info ? {time_seconds, time_fraction} : 32'h0,
      payload_type == TRH_PT_XMIT ? r[7:4] : 4'h0,
      !k && payload_type != TRH_PT_XMIT});
    nx = nx + 16'h0001;
    req = 1'b1;
    for (int j = 0; j < 20 && busy !== 1'b1; j++) @(negedge clk_sys);
    req = 1'b0;
    for (int j = 0; j < 40 && busy !== 1'b0; j++) @(negedge clk_sys);
  endtask

  // ==========
  // result watcher
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test;
    end else if (hv === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : ~{sg, got};
      check({got[78:53], got[4:1]}, {e[78:53], e[4:1]});
      check(got[0], e[0]);
      check(got[52:37], e[52:37]);
      check(sg, e[79]);
      check(got[36:5], e[36:5]);
    end
  end

  initial begin
    void'($urandom(27));
    repeat (6) @(negedge clk_sys);
    sys_rst = 0;
    @(negedge clk_sys);
    seed_load = 1;
    seed_value = 16'hFFFE;
    @(negedge clk_sys);
    seed_load = 0;
    @(negedge clk_sys);
    check(seq_now, 16'hFFFE);
    for (int i = 0; i < 40; i++) begin
      // mid-run reset: counter restarts at zero, extension relocks
      if (i == 20) begin
        repeat (4) @(negedge clk_sys);
        sys_rst = 1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 0;
        nx = 16'h0000;
      end
      send(i);
    end
    repeat (40) @(negedge clk_sys);
    check(79'(exp_q.size()), 79'h0);
    end_of_test;
  end
endmodule
